/* File: inc/sac_pkg.sv */
package sac_pkg;
    localparam int unsigned SAC_RES_BITS = 8;
    localparam int unsigned SAC_ADDR_BITS = 3;
    localparam int unsigned SAC_IDX_BITS = 3;
    // address shift register positions: start, mode, parity
    localparam int unsigned SAC_START_POS = 2;
    localparam int unsigned SAC_SGL_POS = 1;
    localparam int unsigned SAC_ODD_POS = 0;
    localparam logic [SAC_RES_BITS-1:0] SAC_RES_RST = 8'h00;
    localparam logic [SAC_RES_BITS-1:0] SAC_RES_ONE = 8'h01;
    localparam logic [SAC_ADDR_BITS-1:0] SAC_ADDR_RST = 3'h0;
    localparam logic [SAC_IDX_BITS-1:0] SAC_IDX_MSB = 3'h7;
    localparam logic [SAC_IDX_BITS-1:0] SAC_IDX_LSB = 3'h0;
    localparam logic [SAC_IDX_BITS-1:0] SAC_IDX_REPEAT = 3'h1;
    localparam logic [SAC_IDX_BITS-1:0] SAC_IDX_STEP = 3'h1;
    typedef enum logic [5:0] {
        SAC_ST_IDLE = 6'h01,
        SAC_ST_ADDR = 6'h02,
        SAC_ST_SETTLE = 6'h04,
        SAC_ST_MSB = 6'h08,
        SAC_ST_LSB = 6'h10,
        SAC_ST_DONE = 6'h20
    } sac_state_t;
endpackage

/* File: inc/sac_if.sv */
`timescale 1ns/1ns
interface sac_if;
    import sac_pkg::*;
    logic twin;
    logic sgl;
    logic odd;
    logic [SAC_RES_BITS-1:0] in_zero;
    logic [SAC_RES_BITS-1:0] in_one;
    logic [SAC_RES_BITS-1:0] pin_p;
    logic [SAC_RES_BITS-1:0] pin_n;
    logic [SAC_RES_BITS-1:0] diff;
    logic clear;
    logic step;
    logic [SAC_IDX_BITS-1:0] idx;
    logic decide;
    logic [SAC_RES_BITS-1:0] result;
    modport ctl (
        output twin, sgl, odd, in_zero, in_one, pin_p, pin_n, clear, step, idx,
        input diff, decide, result
    );
    modport mux (
        input twin, sgl, odd, in_zero, in_one, pin_p, pin_n,
        output diff
    );
    modport appr (
        input diff, clear, step, idx,
        output decide, result
    );
endinterface

/* File: logic/sac_mux.sv */
`timescale 1ns/1ns
module sac_mux (
    sac_if.mux m
);
    import sac_pkg::*;
    logic [SAC_RES_BITS-1:0] pos;
    logic [SAC_RES_BITS-1:0] neg;
    always_comb begin
        if (!m.twin) begin
            // fixed pair, no address needed
            pos = m.pin_p;
            neg = m.pin_n;
        end else if (m.sgl) begin
            // single-ended against ground
            pos = m.odd ? m.in_one : m.in_zero;
            neg = SAC_RES_RST;
        end else begin
            // differential, parity swaps polarity
            pos = m.odd ? m.in_one : m.in_zero;
            neg = m.odd ? m.in_zero : m.in_one;
        end
        // clamp: a negative difference converts to zero
        m.diff = (pos > neg) ? SAC_RES_BITS'(pos - neg) : SAC_RES_RST;
    end
endmodule

/* File: logic/sac_sar.sv */
`timescale 1ns/1ns
module sac_approx (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // control side
    sac_if.appr s
);
    import sac_pkg::*;
    logic [SAC_RES_BITS-1:0] res_q;
    logic [SAC_RES_BITS-1:0] res_d;
    logic [SAC_RES_BITS-1:0] trial;
    always_comb begin
        // lower bits are still zero, so this is the ladder tap under test
        trial = res_q | SAC_RES_BITS'(SAC_RES_ONE << s.idx);
        s.decide = (s.diff >= trial);
        res_d = res_q;
        if (s.clear) begin
            res_d = SAC_RES_RST;
        end else if (s.step) begin
            res_d[s.idx] = s.decide;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            res_q <= SAC_RES_RST;
        end else begin
            res_q <= res_d;
        end
    end
    assign s.result = res_q;
    appr_store_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (s.step && !s.clear) |=> res_q[$past(s.idx)] == $past(s.decide))
        else $error("decision not stored in result");
    appr_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (s.step && !s.clear && s.diff == SAC_RES_RST) |=> res_q[$past(s.idx)] == 1'b0)
        else $error("zero input gave a one bit");
endmodule

/* File: logic/sac_top.sv */
`timescale 1ns/1ns
module sac_top #(
    parameter bit TWIN_CHANNEL = 1'b1
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // serial link from the host
    input wire logic chip_select_n_i,
    input wire logic ser_clk_i,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_n_o,
    // analog levels, full scale equals reference
    input wire logic [sac_pkg::SAC_RES_BITS-1:0] analog_channel_zero_i,
    input wire logic [sac_pkg::SAC_RES_BITS-1:0] analog_channel_one_i,
    input wire logic [sac_pkg::SAC_RES_BITS-1:0] positive_analog_input_i,
    input wire logic [sac_pkg::SAC_RES_BITS-1:0] negative_analog_input_i,
    // status
    output logic busy_o,
    output logic result_valid_o,
    output logic [sac_pkg::SAC_RES_BITS-1:0] result_o
);
    import sac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // state

    sac_state_t st_q;
    sac_state_t st_d;
    logic clk_q;
    logic clk_d;
    logic [SAC_ADDR_BITS-1:0] addr_q;
    logic [SAC_ADDR_BITS-1:0] addr_d;
    logic [SAC_ADDR_BITS-1:0] addr_nx;
    logic sgl_q;
    logic sgl_d;
    logic odd_q;
    logic odd_d;
    logic [SAC_IDX_BITS-1:0] idx_q;
    logic [SAC_IDX_BITS-1:0] idx_d;
    logic sdo_q;
    logic sdo_d;
    logic oe_n_q;
    logic oe_n_d;
    logic busy_q;
    logic busy_d;
    logic valid_q;
    logic valid_d;
    logic [SAC_RES_BITS-1:0] res_q;
    logic [SAC_RES_BITS-1:0] res_d;
    logic step;
    logic rise;
    logic fall;

    sac_if ifc ();

    sac_mux u_mux (
        .m(ifc.mux)
    );

    sac_approx u_appr (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .s(ifc.appr)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // edges of the host clock, which is taken as synchronous

    assign rise = ser_clk_i && !clk_q;
    assign fall = !ser_clk_i && clk_q;
    assign addr_nx = {addr_q[SAC_ADDR_BITS-2:0], serial_data_in_i};

    assign ifc.twin = TWIN_CHANNEL;
    assign ifc.sgl = sgl_q;
    assign ifc.odd = odd_q;
    assign ifc.in_zero = analog_channel_zero_i;
    assign ifc.in_one = analog_channel_one_i;
    assign ifc.pin_p = positive_analog_input_i;
    assign ifc.pin_n = negative_analog_input_i;
    assign ifc.clear = chip_select_n_i || (st_q == SAC_ST_IDLE);
    assign ifc.step = step;
    assign ifc.idx = idx_q;

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        st_d = st_q;
        clk_d = ser_clk_i;
        addr_d = addr_q;
        sgl_d = sgl_q;
        odd_d = odd_q;
        idx_d = idx_q;
        sdo_d = sdo_q;
        oe_n_d = oe_n_q;
        valid_d = valid_q;
        res_d = res_q;
        step = 1'b0;
        if (chip_select_n_i) begin
            // deselect clears everything and floats the output
            st_d = SAC_ST_IDLE;
            addr_d = SAC_ADDR_RST;
            sgl_d = 1'b0;
            odd_d = 1'b0;
            idx_d = SAC_IDX_MSB;
            sdo_d = 1'b0;
            oe_n_d = 1'b1;
            valid_d = 1'b0;
            res_d = SAC_RES_RST;
        end else begin
            unique case (st_q)
                SAC_ST_IDLE: begin
                    // select low wakes the logic
                    // single variant has no address phase
                    st_d = TWIN_CHANNEL ? SAC_ST_ADDR : SAC_ST_SETTLE;
                end
                SAC_ST_ADDR: begin
                    if (rise) begin
                        // leading zeros fall off the top unnoticed
                        addr_d = addr_nx;
                        if (addr_nx[SAC_START_POS]) begin
                            // start bit at the top: latch the selection
                            sgl_d = addr_nx[SAC_SGL_POS];
                            odd_d = addr_nx[SAC_ODD_POS];
                            st_d = SAC_ST_SETTLE;
                        end
                    end
                end
                SAC_ST_SETTLE: begin
                    if (fall) begin
                        // leading low for the settle clock
                        sdo_d = 1'b0;
                        oe_n_d = 1'b0;
                        idx_d = SAC_IDX_MSB;
                        st_d = SAC_ST_MSB;
                    end
                end
                SAC_ST_MSB: begin
                    if (fall) begin
                        // one decision per clock, sent as made
                        step = 1'b1;
                        sdo_d = ifc.decide;
                        if (idx_q == SAC_IDX_LSB) begin
                            // eighth decision ends the conversion
                            res_d = {ifc.result[SAC_RES_BITS-1:1], ifc.decide};
                            valid_d = 1'b1;
                            idx_d = SAC_IDX_REPEAT;
                            st_d = TWIN_CHANNEL ? SAC_ST_LSB : SAC_ST_DONE;
                        end else begin
                            idx_d = SAC_IDX_BITS'(idx_q - SAC_IDX_STEP);
                        end
                    end
                end
                SAC_ST_LSB: begin
                    if (fall) begin
                        // lsb is shared, the repeat starts at bit one
                        sdo_d = res_q[idx_q];
                        if (idx_q == SAC_IDX_MSB) begin
                            st_d = SAC_ST_DONE;
                        end else begin
                            idx_d = SAC_IDX_BITS'(idx_q + SAC_IDX_STEP);
                        end
                    end
                end
                SAC_ST_DONE: begin
                    // stays here until deselect returns to idle, data input unused
                    if (fall) begin
                        sdo_d = 1'b0;
                        oe_n_d = 1'b1;
                    end
                end
                default: begin
                    st_d = SAC_ST_IDLE;
                end
            endcase
        end
        busy_d = (st_d == SAC_ST_SETTLE) || (st_d == SAC_ST_MSB) || (st_d == SAC_ST_LSB);
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= SAC_ST_IDLE;
            clk_q <= 1'b0;
            addr_q <= SAC_ADDR_RST;
            sgl_q <= 1'b0;
            odd_q <= 1'b0;
            idx_q <= SAC_IDX_MSB;
            sdo_q <= 1'b0;
            oe_n_q <= 1'b1;
            busy_q <= 1'b0;
            valid_q <= 1'b0;
            res_q <= SAC_RES_RST;
        end else begin
            st_q <= st_d;
            clk_q <= clk_d;
            addr_q <= addr_d;
            sgl_q <= sgl_d;
            odd_q <= odd_d;
            idx_q <= idx_d;
            sdo_q <= sdo_d;
            oe_n_q <= oe_n_d;
            busy_q <= busy_d;
            valid_q <= valid_d;
            res_q <= res_d;
        end
    end

    // output stays floating during addressing, so one shared wire works
    assign serial_data_out_o = sdo_q;
    assign serial_data_out_oe_n_o = oe_n_q;
    assign busy_o = busy_q;
    assign result_valid_o = valid_q;
    assign result_o = res_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    deselect_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        chip_select_n_i |=> (oe_n_q && st_q == SAC_ST_IDLE && !valid_q))
        else $error("deselect did not clear and float");
    addr_shift_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!chip_select_n_i && st_q == SAC_ST_ADDR && rise)
        |=> addr_q == {$past(addr_q[SAC_ADDR_BITS-2:0]), $past(serial_data_in_i)})
        else $error("data input not shifted on rising edge");
    start_wait_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!chip_select_n_i && st_q == SAC_ST_ADDR && addr_q == SAC_ADDR_RST && rise
         && !serial_data_in_i) |=> st_q == SAC_ST_ADDR && addr_q == SAC_ADDR_RST)
        else $error("leading low taken as start");
    sel_latch_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (st_q == SAC_ST_ADDR ##1 st_q == SAC_ST_SETTLE)
        |-> sgl_q == addr_q[SAC_SGL_POS] && odd_q == addr_q[SAC_ODD_POS])
        else $error("selection not latched at start");
    settle_low_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!chip_select_n_i && st_q == SAC_ST_SETTLE && fall)
        |=> !oe_n_q && !sdo_q && st_q == SAC_ST_MSB && idx_q == SAC_IDX_MSB)
        else $error("settle clock not driven low");
    msb_bit_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!chip_select_n_i && st_q == SAC_ST_MSB && fall) |=> sdo_q == $past(ifc.decide))
        else $error("output bit differs from decision");
    conv_end_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!chip_select_n_i && st_q == SAC_ST_MSB && fall && idx_q == SAC_IDX_LSB)
        |=> valid_q && st_q != SAC_ST_MSB)
        else $error("conversion not ended after eight bits");
    lsb_bit_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!chip_select_n_i && st_q == SAC_ST_LSB && fall) |=> sdo_q == res_q[$past(idx_q)])
        else $error("lsb-first bit wrong");
    din_ignored_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!chip_select_n_i && st_q != SAC_ST_ADDR && st_q != SAC_ST_IDLE) |=> $stable(addr_q))
        else $error("data input shifted during conversion");
    fall_only_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!chip_select_n_i && $past(!chip_select_n_i) && $changed(sdo_q)) |-> $past(fall))
        else $error("output changed off a falling edge");
    polarity_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (TWIN_CHANNEL && !sgl_q && odd_q && analog_channel_zero_i >= analog_channel_one_i)
        |-> ifc.diff == SAC_RES_RST)
        else $error("differential polarity not reversed");
endmodule

/* File: verification/sac_host.sv */
`timescale 1ns/1ns
module sac_host (
    // clock
    input wire logic sys_clk_i,
    // serial link towards both converters
    output logic chip_select_n_o,
    output logic ser_clk_o,
    output logic serial_data_o,
    // converter outputs, index 0 twin, index 1 single
    input wire logic [1:0] sdo_i,
    input wire logic [1:0] oe_n_i
);
    logic [1:0] smp_do [0:31];
    logic [1:0] smp_oe [0:31];

    initial begin
        chip_select_n_o = 1'h1;
        ser_clk_o = 1'h0;
        serial_data_o = 1'h0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // one frame: z leading zeros, start, mode, parity, then toggling data
    // h is the half period in system clocks; at least 2 so a fall lands before the next rise
    task automatic frame(input int z, input bit sgl, input bit odd, input int n, input int h);
        logic [31:0] tx;
        tx = 32'h0;
        tx[z] = 1'h1;
        tx[z + 1] = sgl;
        tx[z + 2] = odd;
        @(posedge sys_clk_i);
        chip_select_n_o <= 1'h0;
        for (int i = 0; i < n; i++) begin
            wait_clk(1);
            // after the address the line is not left at its last value
            serial_data_o <= (i < z + 3) ? tx[i] : ~serial_data_o;
            wait_clk(h);
            ser_clk_o <= 1'h1;
            smp_do[i] <= sdo_i;
            smp_oe[i] <= oe_n_i;
            wait_clk(h);
            ser_clk_o <= 1'h0;
        end
        wait_clk(h);
    endtask

    // a new conversion always needs a fresh select fall
    task automatic release_cs();
        @(posedge sys_clk_i);
        chip_select_n_o <= 1'h1;
        serial_data_o <= ~serial_data_o;
        wait_clk(3);
    endtask
endmodule

/* File: verification/sac_tb_top.sv */
`timescale 1ns/1ns
module sac_tb_top;
    import sac_pkg::*;
    logic sys_clk, rstn, cs_n, sclk, sdi;
    logic [1:0] sdo, oe_n, busy, valid;
    logic [SAC_RES_BITS-1:0] ain0, ain1, pp, pn, res_t, res_s;
    logic [31:0] rnd;
    int n_errors, tests_run, seed;

    sac_host host (.sys_clk_i(sys_clk), .chip_select_n_o(cs_n), .ser_clk_o(sclk),
        .serial_data_o(sdi), .sdo_i(sdo), .oe_n_i(oe_n));
    sac_top #(.TWIN_CHANNEL(1'h1)) uut (.sys_clk_i(sys_clk), .rstn_i(rstn),
        .chip_select_n_i(cs_n), .ser_clk_i(sclk), .serial_data_in_i(sdi),
        .serial_data_out_o(sdo[0]), .serial_data_out_oe_n_o(oe_n[0]),
        .analog_channel_zero_i(ain0), .analog_channel_one_i(ain1),
        .positive_analog_input_i(pp), .negative_analog_input_i(pn),
        .busy_o(busy[0]), .result_valid_o(valid[0]), .result_o(res_t));
    sac_top #(.TWIN_CHANNEL(1'h0)) uut_single (.sys_clk_i(sys_clk), .rstn_i(rstn),
        .chip_select_n_i(cs_n), .ser_clk_i(sclk), .serial_data_in_i(sdi),
        .serial_data_out_o(sdo[1]), .serial_data_out_oe_n_o(oe_n[1]),
        .analog_channel_zero_i(ain0), .analog_channel_one_i(ain1),
        .positive_analog_input_i(pp), .negative_analog_input_i(pn),
        .busy_o(busy[1]), .result_valid_o(valid[1]), .result_o(res_s));

    initial begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("Checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // expected pin at sample i; -1 means floating
    function automatic int exp_at(input int i, input int a, input int r, input bit tw);
        int k;
        k = i - a;
        if (k < 0) return -1;
        if (k == 0) return 0;
        if (k <= 8) return (r >> (8 - k)) & 1;
        if (tw && k <= 15) return (r >> (k - 8)) & 1;
        return -1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic run(input int z, input bit sgl, input bit odd, input int h, input int n);
        int pos, neg, r_t, r_s, e, f;
        // inputs land by non-blocking assignment, so the model reads them after the frame
        host.frame(z, sgl, odd, n, h);
        pos = odd ? int'(ain1) : int'(ain0);
        neg = sgl ? 0 : (odd ? int'(ain0) : int'(ain1));
        r_t = pos > neg ? pos - neg : 0;
        r_s = pp > pn ? int'(pp) - int'(pn) : 0;
        // index of the last falling edge counted from the twin leading low
        f = n - z - 3;
        for (int i = 0; i < n; i++) begin
            for (int v = 0; v < 2; v++) begin
                e = exp_at(i, (v == 1) ? 1 : z + 3, (v == 1) ? r_s : r_t, v == 0);
                if (e < 0)
                    check({7'h0, host.smp_oe[i][v]}, 8'h01);
                else
                    check({6'h0, host.smp_oe[i][v], host.smp_do[i][v]}, e[7:0]);
            end
        end
        if (n == z + 20) begin
            check(res_t, r_t[7:0]);
            check(res_s, r_s[7:0]);
        end
        // status after the last fall of the frame, single in the upper bit of each pair
        check({4'h0, valid, busy}, {4'h0, n >= 9, f >= 8, n <= 8, f >= 0 && f <= 14});
        host.release_cs();
        check({2'h0, oe_n, valid, busy}, 8'h30);
        check(res_t | res_s, 8'h00);
    endtask

    task automatic set_in(input logic [31:0] a, input logic [31:0] b);
        @(posedge sys_clk);
        ain0 <= a[7:0];
        ain1 <= b[7:0];
        pp <= a[15:8];
        pn <= b[15:8];
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] edge_a [0:2];
        logic [31:0] edge_b [0:2];
        rstn = 1'h0;
        ain0 = 8'h00;
        ain1 = 8'h00;
        pp = 8'h00;
        pn = 8'h00;
        n_errors = 0;
        tests_run = 0;
        seed = 32'h6C24;
        edge_a = '{32'hFFFF, 32'h0000, 32'h8080};
        edge_b = '{32'h0000, 32'hFFFF, 32'h8080};
        repeat (20) @(posedge sys_clk);
        rstn <= 1'h1;
        @(posedge sys_clk);
        @(posedge sys_clk);
        check({2'h0, oe_n, valid, busy}, 8'h30);
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 3; k++) begin
                rnd = $random(seed);
                set_in(rnd, {rnd[15:0], rnd[31:16]});
                run(k, m[1], m[0], 2 + 2 * (k % 2), k + 20);
            end
            set_in(edge_a[m % 3], edge_b[m % 3]);
            run(0, m[1], m[0], 3, 20);
        end
        // abort in mid-stream, then a clean conversion right after
        run(1, 1'h0, 1'h0, 2, 9);
        run(2, 1'h1, 1'h1, 2, 22);
        end_sim();
    end

    initial begin
        repeat (30000) @(posedge sys_clk);
        n_errors++;
        $display("Error at %0t: watchdog expired %0h %0h", $time, 0, 1);
        end_sim();
    end
endmodule
